// ### hw/irq_state_ctrl.sv
// Purpose: per-interrupt enable, pending, active and priority state with selection
// Assumes: registers reached by a simple word port; core reports entry and return
// Notes: read data arrives one clock after the read strobe
//
// Notes on behaviour
// RULE_01: writing one to enable-set enables that interrupt; zero ignored; read shows enables.
// RULE_02: writing one to enable-clear disables that interrupt; zero ignored; read shows enables.
// RULE_03: an enabled pending interrupt is offered to the core by priority.
// RULE_04: a disabled interrupt still pends but is never offered while disabled.
// RULE_05: writing one to pending-set makes it pending; zero ignored; read shows pending.
// RULE_06: pending-set leaves pending ones unchanged and also pends disabled ones.
// RULE_07: writing one to pending-clear removes pending; zero ignored; read shows pending.
// RULE_08: pending-clear never changes the active state.
// RULE_09: each interrupt has priority 0 to 3 in its own byte lane; lower is urgent.
// RULE_10: only bits 7:6 of each priority byte are kept; bits 5:0 read zero.
// RULE_11: priority words are accessed only as whole words by software.
// RULE_12: priority of interrupt m is in word m div 4, lane m mod 4.
// RULE_13: pulse lines are sampled each clock and a seen pulse is latched pending.
// RULE_14: a pulse source holds its line high for at least one clock.
// RULE_15: a level source holds its line high until serviced, then drops it.
// RULE_16: pending comes from line high while not active, a rising edge, or software.
// RULE_17: on routine entry the interrupt loses pending and becomes active.
// RULE_18: on level return, line high means pending again, else inactive.
// RULE_19: a pulse during active gives active and pending; return then leaves pending.
// RULE_20: level pending-clear does nothing while the line stays high, else goes inactive.
// RULE_21: pulse pending-clear: pending goes inactive, active-and-pending goes active.
// RULE_22: reset clears enables, pending, active and priorities.
// RULE_23: lowest priority value wins among eligible ones; ties go to the lowest number.
`timescale 1ns/1ps
module irq_state_ctrl #(
  parameter int NUM_IRQ = 32
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // peripheral request lines and per-line kind, 1 = level
  input wire logic [NUM_IRQ-1:0] irq_lines_i,
  input wire logic [NUM_IRQ-1:0] level_sense_i,
  // register word port
  input wire logic [11:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  // core handshake
  input wire irq_ctrl_pkg::core_evt_t entry_i,
  input wire irq_ctrl_pkg::core_evt_t exit_i,
  output irq_ctrl_pkg::irq_offer_t offer_o,
  // state view
  output logic [NUM_IRQ-1:0] pending_o,
  output logic [NUM_IRQ-1:0] active_o
);

  // ==========================================================================
  // parameter check
  if (NUM_IRQ < 1 || NUM_IRQ > irq_ctrl_pkg::MAX_IRQ)
  begin : g_bad_num
    $error("NUM_IRQ must lie between 1 and 32");
  end

  // ==========================================================================
  // helpers
  function automatic logic [NUM_IRQ-1:0] one_hot(input irq_ctrl_pkg::core_evt_t evt);
    logic [NUM_IRQ-1:0] v;
    v = '0;
    for (int i = 0; i < NUM_IRQ; i++)
    begin
      if (evt.valid && evt.id == 5'(i))
      begin
        v[i] = 1'b1;
      end
    end
    return v;
  endfunction : one_hot

  function automatic logic [31:0] widen(input logic [NUM_IRQ-1:0] v);
    logic [31:0] w;
    w = irq_ctrl_pkg::WORD_RESET;
    w[NUM_IRQ-1:0] = v;
    return w;
  endfunction : widen

  // ==========================================================================
  // state
  logic [NUM_IRQ-1:0] enable_reg;
  logic [NUM_IRQ-1:0] pend_reg;
  logic [NUM_IRQ-1:0] active_reg;
  logic [NUM_IRQ-1:0][1:0] prio_reg;
  logic [NUM_IRQ-1:0] line_level;
  logic [NUM_IRQ-1:0] line_rise;

  // request lines cross into the core clock before any use
  irq_line_sync #(
    .WIDTH(NUM_IRQ)
  ) u_line_sync (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .lines_i(irq_lines_i),
    .level_o(line_level),
    .rise_o(line_rise)
  );

  // ==========================================================================
  // write decode
  logic wr_en_set;
  logic wr_en_clr;
  logic wr_pend_set;
  logic wr_pend_clr;
  logic wr_prio;
  logic [2:0] prio_word;
  logic [NUM_IRQ-1:0] wmask;

  assign wr_en_set = reg_wr_i && reg_addr_i == irq_ctrl_pkg::ENABLE_SET_OFS;
  assign wr_en_clr = reg_wr_i && reg_addr_i == irq_ctrl_pkg::ENABLE_CLR_OFS;
  assign wr_pend_set = reg_wr_i && reg_addr_i == irq_ctrl_pkg::PENDING_SET_OFS;
  assign wr_pend_clr = reg_wr_i && reg_addr_i == irq_ctrl_pkg::PENDING_CLR_OFS;
  // word access only; byte writes are not decoded separately
  assign wr_prio = reg_wr_i && reg_addr_i >= irq_ctrl_pkg::PRIO_BASE_OFS
    && reg_addr_i <= irq_ctrl_pkg::PRIO_LAST_OFS && reg_addr_i[1:0] == 2'h0; // see RULE_11
  assign prio_word = reg_addr_i[4:2];
  assign wmask = reg_wdata_i[NUM_IRQ-1:0];

  // ==========================================================================
  // enable bits: set and clear only touch the written ones
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      enable_reg <= '0; // see RULE_22
    end
    else if (wr_en_set)
    begin
      enable_reg <= enable_reg | wmask; // see RULE_01
    end
    else if (wr_en_clr)
    begin
      enable_reg <= enable_reg & ~wmask; // see RULE_02
    end
  end

  // ==========================================================================
  // pending and active transitions
  logic [NUM_IRQ-1:0] entry_vec;
  logic [NUM_IRQ-1:0] exit_vec;
  logic [NUM_IRQ-1:0] hw_set;
  logic [NUM_IRQ-1:0] sw_set;
  logic [NUM_IRQ-1:0] sw_clr;
  logic [NUM_IRQ-1:0] level_return;

  assign entry_vec = one_hot(entry_i);
  assign exit_vec = one_hot(exit_i);
  // level pends while not active; entry counts as active so the line does not re-pend at once
  assign hw_set = (level_sense_i & line_level & ~(active_reg | entry_vec))
    | (~level_sense_i & line_rise); // see RULE_13 see RULE_16 see RULE_19
  assign sw_set = wr_pend_set ? wmask : '0; // see RULE_05 see RULE_06
  // a level line still high keeps its state against a software clear
  assign sw_clr = wr_pend_clr ? (wmask & ~(level_sense_i & line_level)) : '0; // see RULE_07 see RULE_20 see RULE_21
  assign level_return = exit_vec & level_sense_i & line_level; // see RULE_18

  // set terms win over clear terms in the same cycle
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pend_reg <= '0;
    end
    else
    begin
      pend_reg <= (pend_reg & ~(sw_clr | entry_vec)) | hw_set | sw_set | level_return; // see RULE_17 see RULE_04
    end
  end

  // only core entry and return move the active bit
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      active_reg <= '0;
    end
    else
    begin
      active_reg <= (active_reg | entry_vec) & ~exit_vec; // see RULE_08 see RULE_17
    end
  end

  // ==========================================================================
  // priority fields, top two bits of each byte lane
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < NUM_IRQ; i++)
      begin
        prio_reg[i] <= irq_ctrl_pkg::PRIO_RESET;
      end
    end
    else if (wr_prio)
    begin
      for (int i = 0; i < NUM_IRQ; i++)
      begin
        if (3'(i / irq_ctrl_pkg::LANES_PER_WORD) == prio_word)
        begin
          prio_reg[i] <= reg_wdata_i[(i % irq_ctrl_pkg::LANES_PER_WORD) * 8
            + irq_ctrl_pkg::PRIO_LSB +: irq_ctrl_pkg::PRIO_WIDTH]; // see RULE_09 see RULE_10 see RULE_12
        end
      end
    end
  end

  // ==========================================================================
  // read path, one clock latency, unmapped reads give zero
  logic [31:0] prio_read;

  always_comb
  begin
    prio_read = irq_ctrl_pkg::WORD_RESET;
    for (int i = 0; i < NUM_IRQ; i++)
    begin
      if (3'(i / irq_ctrl_pkg::LANES_PER_WORD) == prio_word)
      begin
        prio_read[(i % irq_ctrl_pkg::LANES_PER_WORD) * 8 + irq_ctrl_pkg::PRIO_LSB +: irq_ctrl_pkg::PRIO_WIDTH]
          = prio_reg[i]; // see RULE_10 see RULE_12
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      reg_rdata_o <= irq_ctrl_pkg::WORD_RESET;
    end
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        irq_ctrl_pkg::ENABLE_SET_OFS: reg_rdata_o <= widen(enable_reg); // see RULE_01
        irq_ctrl_pkg::ENABLE_CLR_OFS: reg_rdata_o <= widen(enable_reg); // see RULE_02
        irq_ctrl_pkg::PENDING_SET_OFS: reg_rdata_o <= widen(pend_reg); // see RULE_05
        irq_ctrl_pkg::PENDING_CLR_OFS: reg_rdata_o <= widen(pend_reg); // see RULE_07
        default:
        begin
          if (reg_addr_i >= irq_ctrl_pkg::PRIO_BASE_OFS && reg_addr_i <= irq_ctrl_pkg::PRIO_LAST_OFS
            && reg_addr_i[1:0] == 2'h0)
          begin
            reg_rdata_o <= prio_read;
          end
          else
          begin
            reg_rdata_o <= irq_ctrl_pkg::WORD_RESET;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // selection: lowest value first, scan upward so ties keep the lowest number
  logic sel_valid;
  logic [4:0] sel_id;
  logic [1:0] sel_prio;
  logic [NUM_IRQ-1:0] eligible;

  // active ones are held back; nesting by level is the core's business
  assign eligible = pend_reg & enable_reg & ~active_reg; // see RULE_03 see RULE_04

  always_comb
  begin
    sel_valid = 1'b0;
    sel_id = 5'h0;
    sel_prio = 2'h3;
    for (int i = 0; i < NUM_IRQ; i++)
    begin
      if (eligible[i] && (!sel_valid || prio_reg[i] < sel_prio))
      begin
        sel_valid = 1'b1;
        sel_id = 5'(i);
        sel_prio = prio_reg[i]; // see RULE_23
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      offer_o <= '0;
    end
    else
    begin
      offer_o.valid <= sel_valid;
      offer_o.id <= sel_id;
      offer_o.prio <= sel_prio;
    end
  end

  // state view for the core and for debug
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pending_o <= '0;
      active_o <= '0;
    end
    else
    begin
      pending_o <= pend_reg;
      active_o <= active_reg;
    end
  end

  // ==========================================================================
  // checks
  chk_enable_set_bits: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RULE_01
    wr_en_set |=> ((enable_reg & $past(wmask)) == $past(wmask)) && ((enable_reg & ~$past(wmask))
      == ($past(enable_reg) & ~$past(wmask))))
    else $error("enable set write did not set exactly the written bits");

  chk_enable_clear_bits: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RULE_02
    wr_en_clr |=> ((enable_reg & $past(wmask)) == '0) && (enable_reg == ($past(enable_reg) & ~$past(wmask))))
    else $error("enable clear write did not clear exactly the written bits");

  chk_offer_is_eligible: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RULE_04
    sel_valid |-> enable_reg[sel_id] && pend_reg[sel_id] && !active_reg[sel_id])
    else $error("selected interrupt is not enabled and pending");

  chk_pending_set_write: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RULE_05
    wr_pend_set && !entry_i.valid |=> (pend_reg & $past(wmask)) == $past(wmask))
    else $error("pending set write lost a bit");

  chk_clear_keeps_active: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RULE_08
    wr_pend_clr && !entry_i.valid && !exit_i.valid |=> active_reg == $past(active_reg))
    else $error("pending clear changed the active state");

  chk_prio_low_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RULE_10
    reg_rd_i |=> (reg_rdata_o & irq_ctrl_pkg::PRIO_UNUSED_MASK) == '0
      || !($past(reg_addr_i) >= irq_ctrl_pkg::PRIO_BASE_OFS && $past(reg_addr_i) <= irq_ctrl_pkg::PRIO_LAST_OFS))
    else $error("priority word shows bits in the unused positions");

  chk_pulse_latched: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RULE_13
    (line_rise & ~level_sense_i) != '0 |=> (pend_reg & $past(line_rise & ~level_sense_i))
      == $past(line_rise & ~level_sense_i))
    else $error("pulse seen but not latched pending");

  chk_entry_makes_active: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RULE_17
    entry_i.valid && !(exit_i.valid && exit_i.id == entry_i.id) |=> active_reg[$past(entry_i.id)] ##1
      active_o[$past(entry_i.id, 2)])
    else $error("entry did not mark the interrupt active");

  chk_reset_clears_all: assert property (@(posedge core_clk_i) // see RULE_22
    $rose(rstn_i) |-> enable_reg == '0 && pend_reg == '0 && active_reg == '0 && prio_reg == '0)
    else $error("state not cleared by reset");

  chk_level_return: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // see RULE_18
    exit_i.valid && level_sense_i[exit_i.id] && line_level[exit_i.id] |=> pend_reg[$past(exit_i.id)]
      && !active_reg[$past(exit_i.id)])
    else $error("level return with line high did not pend again");

endmodule : irq_state_ctrl

// ### hw/irq_ctrl_pkg.sv
// Purpose: shared constants and carriers for the vectored interrupt state logic
// Assumes: register offsets are byte offsets inside the core private block at 0xe000e000
// Notes: priority words hold one 2-bit field at the top of each byte lane
package irq_ctrl_pkg;

  // ==========================================================================
  // register map, byte offsets
  localparam logic [11:0] ENABLE_SET_OFS = 12'h100;
  localparam logic [11:0] ENABLE_CLR_OFS = 12'h180;
  localparam logic [11:0] PENDING_SET_OFS = 12'h200;
  localparam logic [11:0] PENDING_CLR_OFS = 12'h280;
  localparam logic [11:0] PRIO_BASE_OFS = 12'h400;
  localparam logic [11:0] PRIO_LAST_OFS = 12'h41c;

  // ==========================================================================
  // field layout and reset values
  localparam int PRIO_WIDTH = 2;
  localparam int PRIO_LSB = 6;
  localparam int LANES_PER_WORD = 4;
  localparam int MAX_IRQ = 32;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [1:0] PRIO_RESET = 2'h0;
  localparam logic [31:0] PRIO_UNUSED_MASK = 32'h3f3f_3f3f;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic [4:0] id;
  } core_evt_t;

  typedef struct packed {
    logic valid;
    logic [4:0] id;
    logic [1:0] prio;
  } irq_offer_t;

endpackage : irq_ctrl_pkg

// ### hw/irq_line_sync.sv
// Purpose: bring peripheral request lines into the core clock and find rising edges
// Assumes: lines are asynchronous to core_clk_i
// Notes: edge is taken between second stage and a history stage, never the first
`timescale 1ns/1ps
module irq_line_sync #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // raw lines
  input wire logic [WIDTH-1:0] lines_i,
  // synchronised level and rise
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] hist_reg;

  // ==========================================================================
  // two-stage synchroniser plus history for the edge
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      hist_reg <= '0;
    end
    else
    begin
      meta_reg <= lines_i;
      sync_reg <= meta_reg;
      hist_reg <= sync_reg;
    end
  end

  // a pulse held for one clock is seen here once it clears the synchroniser
  assign level_o = sync_reg;
  assign rise_o = sync_reg & ~hist_reg;

endmodule : irq_line_sync

// ### test/irq_source_model.sv
// Purpose: peripheral request sources facing the interrupt state logic
// Assumes: one source per line, changed just after a core clock edge
// Notes: pulse and level sources share one line vector
`timescale 1ns/1ps
module irq_source_model #(
  parameter int NUM_IRQ = 32
) (
  // clock
  input wire logic core_clk_i,
  // request lines, active high
  output logic [NUM_IRQ-1:0] lines_o
);
  // ==========================================================================
  // line drivers
  initial lines_o = '0;

  // one cycle high is the shortest pulse a source may give
  task automatic pulse(input int n);
    @(posedge core_clk_i);
    lines_o[n] <= 1'b1;
    @(posedge core_clk_i);
    lines_o[n] <= 1'b0;
  endtask : pulse

  // level source stays high until its routine has serviced it
  task automatic raise(input int n);
    @(posedge core_clk_i);
    lines_o[n] <= 1'b1;
  endtask : raise

  // dropped only once serviced
  task automatic drop(input int n);
    @(posedge core_clk_i);
    lines_o[n] <= 1'b0;
  endtask : drop
endmodule : irq_source_model

// ### test/irq_state_ctrl_bench.sv
// Purpose: self-checking bench for the interrupt state logic
// Assumes: line 3 pulse type, line 8 level type
// Notes: waits of six cycles cover the four-cycle line latency
`timescale 1ns/1ps
module irq_state_ctrl_bench;
  // ==========================================================================
  // signals
  logic core_clk_i;
  logic rstn_i;
  logic [31:0] irq_lines_i;
  logic [31:0] level_sense_i;
  logic [11:0] reg_addr_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [31:0] reg_wdata_i;
  logic [31:0] reg_rdata_o;
  irq_ctrl_pkg::core_evt_t entry_i;
  irq_ctrl_pkg::core_evt_t exit_i;
  irq_ctrl_pkg::irq_offer_t offer_o;
  logic [31:0] pending_o;
  logic [31:0] active_o;
  int n_fail;
  int tests_run;

  // ==========================================================================
  // design and sources
  irq_state_ctrl #(.NUM_IRQ(32)) dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .irq_lines_i(irq_lines_i), .level_sense_i(level_sense_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .entry_i(entry_i), .exit_i(exit_i), .offer_o(offer_o),
    .pending_o(pending_o), .active_o(active_o));
  irq_source_model #(.NUM_IRQ(32)) src (.core_clk_i(core_clk_i), .lines_o(irq_lines_i));

  // ==========================================================================
  // clock, 100 MHz
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // ==========================================================================
  // helpers
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // one-cycle write strobe, taken at the second edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // data is sampled one edge after the taken edge, where it stands
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk("rdata", e, reg_rdata_o);
  endtask : rd

  // core entry or return pulse for one id
  task automatic evt(input logic ex, input logic [4:0] id);
    @(posedge core_clk_i);
    if (ex)
      exit_i <= '{valid: 1'b1, id: id};
    else
      entry_i <= '{valid: 1'b1, id: id};
    @(posedge core_clk_i);
    entry_i <= '0;
    exit_i <= '0;
  endtask : evt

  task automatic settle;
    repeat (6) @(posedge core_clk_i);
    #1;
  endtask : settle

  task automatic st(input logic [31:0] p, input logic [31:0] a);
    settle();
    chk("pending", p, pending_o);
    chk("active", a, active_o);
  endtask : st

  task automatic off(input logic [7:0] e);
    chk("offer", {24'h0, e}, {24'h0, offer_o});
  endtask : off

  // ==========================================================================
  // watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    n_fail++;
    print_verdict();
  end

  // ==========================================================================
  // tests
  initial
  begin
    n_fail = 0;
    tests_run = 0;
    rstn_i = 1'b0;
    level_sense_i = 32'h0000_0100;
    reg_addr_i = 12'h000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_wdata_i = 32'h0000_0000;
    entry_i = '0;
    exit_i = '0;
    repeat (10) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    // reset values of every register, then an unmapped place
    rd(irq_ctrl_pkg::ENABLE_SET_OFS, 32'h0);
    rd(irq_ctrl_pkg::PENDING_SET_OFS, 32'h0);
    for (int k = 0; k < 8; k++)
      rd(irq_ctrl_pkg::PRIO_BASE_OFS + 12'(4 * k), 32'h0);
    rd(12'h300, 32'h0);
    // enables: set, zero ignored, clear
    wr(irq_ctrl_pkg::ENABLE_SET_OFS, 32'h0000_0109);
    wr(irq_ctrl_pkg::ENABLE_SET_OFS, 32'h0000_0000);
    rd(irq_ctrl_pkg::ENABLE_SET_OFS, 32'h0000_0109);
    wr(irq_ctrl_pkg::ENABLE_CLR_OFS, 32'h0000_0001);
    rd(irq_ctrl_pkg::ENABLE_CLR_OFS, 32'h0000_0108);
    // priority fields keep only the top two bits of each lane
    wr(irq_ctrl_pkg::PRIO_BASE_OFS, 32'hffff_ffff);
    rd(irq_ctrl_pkg::PRIO_BASE_OFS, 32'hc0c0_c0c0);
    wr(irq_ctrl_pkg::PRIO_BASE_OFS, 32'h8000_0000);
    wr(12'h408, 32'h0000_0040);
    // software pend of two enabled and one disabled at priority 0
    wr(irq_ctrl_pkg::PENDING_SET_OFS, 32'h0000_0109);
    rd(irq_ctrl_pkg::PENDING_SET_OFS, 32'h0000_0109);
    settle();
    off({1'b1, 5'h08, 2'h1});
    wr(irq_ctrl_pkg::PENDING_SET_OFS, 32'h0000_0001);
    rd(irq_ctrl_pkg::PENDING_CLR_OFS, 32'h0000_0109);
    wr(irq_ctrl_pkg::PENDING_CLR_OFS, 32'h0000_0101);
    rd(irq_ctrl_pkg::PENDING_CLR_OFS, 32'h0000_0008);
    settle();
    off({1'b1, 5'h03, 2'h2});
    // pulse line through entry, pulse while active, clear and return
    evt(1'b0, 5'h03);
    st(32'h0, 32'h8);
    chk("offer_v", 32'h0, {31'h0, offer_o.valid});
    src.pulse(3);
    st(32'h8, 32'h8);
    wr(irq_ctrl_pkg::PENDING_CLR_OFS, 32'h0000_0008);
    st(32'h0, 32'h8);
    src.pulse(3);
    evt(1'b1, 5'h03);
    st(32'h8, 32'h0);
    evt(1'b0, 5'h03);
    evt(1'b1, 5'h03);
    st(32'h0, 32'h0);
    // level line: pend, entry, return while high, clear while high
    src.raise(8);
    st(32'h100, 32'h0);
    off({1'b1, 5'h08, 2'h1});
    evt(1'b0, 5'h08);
    st(32'h0, 32'h100);
    evt(1'b1, 5'h08);
    st(32'h100, 32'h0);
    wr(irq_ctrl_pkg::PENDING_CLR_OFS, 32'h0000_0100);
    st(32'h100, 32'h0);
    src.drop(8);
    // the low line needs the synchroniser latency before a clear can take
    settle();
    wr(irq_ctrl_pkg::PENDING_CLR_OFS, 32'h0000_0100);
    st(32'h0, 32'h0);
    // equal priorities go to the lower number
    wr(12'h408, 32'h0000_0080);
    wr(irq_ctrl_pkg::PENDING_SET_OFS, 32'h0000_0108);
    settle();
    off({1'b1, 5'h03, 2'h2});
    // line 8 turned pulse type: a held-high line pends once, not again on return
    @(posedge core_clk_i);
    level_sense_i <= 32'h0000_0000;
    wr(irq_ctrl_pkg::PENDING_CLR_OFS, 32'h0000_0108);
    st(32'h0, 32'h0);
    src.raise(8);
    st(32'h100, 32'h0);
    evt(1'b0, 5'h08);
    evt(1'b1, 5'h08);
    st(32'h0, 32'h0);
    src.drop(8);
    print_verdict();
  end
endmodule : irq_state_ctrl_bench
